// [rtl/ata_gate_pkg.sv]
// Shared constants and types for the ATA pin gating and presence block.
package ata_gate_pkg;
    // Clock rate and the startup delay before address and selects drive.
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned STARTUP_DELAY_MS = 2;
    localparam int unsigned STARTUP_DELAY_CYCLES =
        (STARTUP_DELAY_MS * CLK_HZ + 999) / 1000;

    // Register byte offsets.
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  CFG_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS   = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0]  EP_DATA_OFS  = 8'h10;

    // Configuration byte layout and reset value.
    localparam logic [7:0]  CFG_RESET            = 8'h00;
    localparam int          CFG_PRES_EN_BIT      = 0;
    localparam int          CFG_PRES_POL_BIT     = 1;
    localparam int          CFG_IGNORE_SENSE_BIT = 4;
    localparam int          CFG_GPI_MODE_BIT     = 7;

    // Interrupt endpoint byte 0 layout.
    localparam int          EP_MEDIA_BIT  = 0;
    localparam int          EP_GRANT_BIT  = 1;
    localparam int          EP_PULLUP_BIT = 2;

    // Event bits, shared by status and mask registers.
    localparam int          EV_W         = 4;
    localparam int          EV_MEDIA     = 0;
    localparam int          EV_ACTIVE    = 1;
    localparam int          EV_READY     = 2;
    localparam int          EV_DRIVE_IRQ = 3;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {WR_IDLE = 2'h1, WR_RESP = 2'h2} wr_state_t;
    typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_DATA = 2'h2} rd_state_t;
endpackage

// [rtl/reg_bus_if.sv]
// Internal register access bus between the bus slave and the register file.
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                      input wr_err, rd_data, rd_err);
    modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                      output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// [rtl/startup_delay.sv]
// Counter that raises a level once the startup delay has elapsed.
`timescale 1ns/1ps
`default_nettype none
module startup_delay #(
    parameter int unsigned CYCLES = ata_gate_pkg::STARTUP_DELAY_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    output logic      done_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_reg;

    // Counts from reset release; done stays high until the next reset.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            done_o  <= 1'h0;
        end else if (!done_o) begin
            cnt_reg <= cnt_reg + CW'(1);
            done_o  <= (cnt_reg == LAST);
        end
    end
endmodule // startup_delay
`default_nettype wire

// [rtl/axil_reg_slave.sv]
// AXI4-Lite slave that turns bus traffic into register bus accesses.
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    reg_bus_if.bus_side      rb
);
    ata_gate_pkg::wr_state_t wr_state;
    ata_gate_pkg::rd_state_t rd_state;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    // Address and data are held apart so they may arrive in either order.
    assign awready_o  = (wr_state == ata_gate_pkg::WR_IDLE) && !aw_have;
    assign wready_o   = (wr_state == ata_gate_pkg::WR_IDLE) && !w_have;
    assign rb.wr_en   = (wr_state == ata_gate_pkg::WR_IDLE) && aw_have
                        && w_have;
    assign rb.wr_addr = waddr_reg;
    assign rb.wr_data = wdata_reg;
    assign rb.wr_strb = wstrb_reg;
    assign arready_o  = (rd_state == ata_gate_pkg::RD_IDLE);
    assign rb.rd_addr = araddr_i;

    // Write channel: collect both halves, commit, then answer.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_state  <= ata_gate_pkg::WR_IDLE;
            aw_have   <= 1'h0;
            w_have    <= 1'h0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_o  <= 1'h0;
            bresp_o   <= ata_gate_pkg::RESP_OKAY;
        end else begin
            unique case (wr_state)
                ata_gate_pkg::WR_IDLE: begin
                    if (awvalid_i && !aw_have) begin
                        aw_have   <= 1'h1;
                        waddr_reg <= awaddr_i;
                    end
                    if (wvalid_i && !w_have) begin
                        w_have    <= 1'h1;
                        wdata_reg <= wdata_i;
                        wstrb_reg <= wstrb_i;
                    end
                    if (aw_have && w_have) begin
                        aw_have  <= 1'h0;
                        w_have   <= 1'h0;
                        bvalid_o <= 1'h1;
                        bresp_o  <= rb.wr_err ? ata_gate_pkg::RESP_SLVERR
                                              : ata_gate_pkg::RESP_OKAY;
                        wr_state <= ata_gate_pkg::WR_RESP;
                    end
                end
                ata_gate_pkg::WR_RESP: begin
                    if (bready_i) begin
                        bvalid_o <= 1'h0;
                        wr_state <= ata_gate_pkg::WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Read channel: data are captured on the address edge.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_state <= ata_gate_pkg::RD_IDLE;
            rvalid_o <= 1'h0;
            rdata_o  <= 32'h0;
            rresp_o  <= ata_gate_pkg::RESP_OKAY;
        end else begin
            unique case (rd_state)
                ata_gate_pkg::RD_IDLE: begin
                    if (arvalid_i) begin
                        rvalid_o <= 1'h1;
                        rdata_o  <= rb.rd_data;
                        rresp_o  <= rb.rd_err ? ata_gate_pkg::RESP_SLVERR
                                              : ata_gate_pkg::RESP_OKAY;
                        rd_state <= ata_gate_pkg::RD_DATA;
                    end
                end
                ata_gate_pkg::RD_DATA: begin
                    if (rready_i) begin
                        rvalid_o <= 1'h0;
                        rd_state <= ata_gate_pkg::RD_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // axil_reg_slave
`default_nettype wire

// [rtl/ata_pin_gating.sv]
// Top of the ATA pin gating, startup drive and media presence block.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ata_pin_gating #(
    parameter int unsigned DELAY_CYCLES  = ata_gate_pkg::STARTUP_DELAY_CYCLES,
    parameter int          DATA_W        = 16,
    parameter bit          GPI_SUPPORTED = 1'b1
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [7:0]        s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [7:0]        s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              host_power_sense_enable_i,
    input  wire logic              media_present_in_i,
    input  wire logic              drive_irq_in_i,
    output logic [2:0]             ata_addr_o,
    output logic                   ata_addr_oe_n_o,
    output logic                   ata_select0_n_o,
    output logic                   ata_select1_n_o,
    output logic                   ata_select_oe_n_o,
    input  wire logic [DATA_W-1:0] ata_data_i,
    output logic [DATA_W-1:0]      ata_data_o,
    output logic                   ata_data_oe_n_o,
    input  wire logic [DATA_W-1:0] xfer_data_i,
    input  wire logic              xfer_drive_i,
    output logic [DATA_W-1:0]      xfer_data_o,
    input  wire logic              pullup_source_pin_i,
    output logic                   pullup_source_pin_o,
    output logic                   pullup_source_pin_oe_n_o,
    input  wire logic              pullup_enable_i,
    input  wire logic              power_grant_n_i,
    output logic                   power_grant_n_o,
    output logic                   power_grant_n_oe_n_o,
    input  wire logic              power_granted_i,
    output logic [15:0]            interrupt_in_endpoint_o,
    output logic                   pins_active_o,
    output logic                   media_present_o,
    output logic                   irq_o
);
    localparam int EV_W_L = ata_gate_pkg::EV_W - 1;

    reg_bus_if rb ();

    logic [7:0]      cfg_reg;
    logic            active_reg;
    logic            active_next;
    logic            present_reg;
    logic            present_next;
    logic            startup_done;
    logic            done_q_reg;
    logic            drive_irq_q_reg;
    logic            gpi_mode;
    logic            drive_en;
    logic [15:0]     ep_reg;
    logic [EV_W_L:0] irq_stat_reg;
    logic [EV_W_L:0] irq_mask_reg;
    logic [EV_W_L:0] ev_vec;
    logic [EV_W_L:0] ev_clr;

    // Bus protocol handling lives in its own module.
    axil_reg_slave u_bus (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .awaddr_i  (s_axi_awaddr_i),
        .awvalid_i (s_axi_awvalid_i),
        .awready_o (s_axi_awready_o),
        .wdata_i   (s_axi_wdata_i),
        .wstrb_i   (s_axi_wstrb_i),
        .wvalid_i  (s_axi_wvalid_i),
        .wready_o  (s_axi_wready_o),
        .bresp_o   (s_axi_bresp_o),
        .bvalid_o  (s_axi_bvalid_o),
        .bready_i  (s_axi_bready_i),
        .araddr_i  (s_axi_araddr_i),
        .arvalid_i (s_axi_arvalid_i),
        .arready_o (s_axi_arready_o),
        .rdata_o   (s_axi_rdata_o),
        .rresp_o   (s_axi_rresp_o),
        .rvalid_o  (s_axi_rvalid_o),
        .rready_i  (s_axi_rready_i),
        .rb        (rb.bus_side)
    );

    // The startup wait runs once from reset release.
    startup_delay #(
        .CYCLES (DELAY_CYCLES)
    ) u_delay (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .done_o (startup_done)
    );

    // Configuration byte, written through byte lane 0 only.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_reg <= ata_gate_pkg::CFG_RESET;
        end else if (rb.wr_en && rb.wr_strb[0]
                     && rb.wr_addr == ata_gate_pkg::CFG_OFS) begin
            cfg_reg <= rb.wr_data[7:0];
        end
    end

    // Alternate input role only exists on variants built with it.
    assign gpi_mode = GPI_SUPPORTED && cfg_reg[ata_gate_pkg::CFG_GPI_MODE_BIT];

    // Pin group is live when the sense input is ignored or asserted.
    assign active_next = cfg_reg[ata_gate_pkg::CFG_IGNORE_SENSE_BIT]
                         || host_power_sense_enable_i;

    // Presence is reported as present when detection is off or in input mode,
    // so a board without the detect pin never looks empty.
    assign present_next = (cfg_reg[ata_gate_pkg::CFG_PRES_EN_BIT] && !gpi_mode)
        ? (media_present_in_i ^ cfg_reg[ata_gate_pkg::CFG_PRES_POL_BIT])
        : 1'h1;

    // Registered views of gating, presence and edge history.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            active_reg      <= 1'h0;
            present_reg     <= 1'h1;
            done_q_reg      <= 1'h0;
            drive_irq_q_reg <= 1'h0;
        end else begin
            active_reg      <= active_next;
            present_reg     <= present_next;
            done_q_reg      <= startup_done;
            drive_irq_q_reg <= drive_irq_in_i;
        end
    end

    assign drive_en = active_reg && startup_done;

    // ATA pin drive; everything floats until both gating and the wait allow.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ata_addr_o        <= 3'h0;
            ata_addr_oe_n_o   <= 1'h1;
            ata_select0_n_o   <= 1'h0;
            ata_select1_n_o   <= 1'h0;
            ata_select_oe_n_o <= 1'h1;
            ata_data_o        <= '0;
            ata_data_oe_n_o   <= 1'h1;
            xfer_data_o       <= '0;
        end else begin
            ata_addr_o        <= {3{drive_en}};
            ata_addr_oe_n_o   <= !drive_en;
            ata_select0_n_o   <= drive_en;
            ata_select1_n_o   <= drive_en;
            ata_select_oe_n_o <= !drive_en;
            ata_data_o        <= xfer_data_i;
            ata_data_oe_n_o   <= !(drive_en && xfer_drive_i);
            xfer_data_o       <= active_reg ? ata_data_i : '0;
        end
    end

    // Side pins turn into inputs in the alternate role.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pullup_source_pin_o      <= 1'h0;
            pullup_source_pin_oe_n_o <= 1'h1;
            power_grant_n_o          <= 1'h1;
            power_grant_n_oe_n_o     <= 1'h1;
        end else begin
            pullup_source_pin_o      <= pullup_enable_i;
            pullup_source_pin_oe_n_o <= gpi_mode;
            power_grant_n_o          <= !power_granted_i;
            power_grant_n_oe_n_o     <= gpi_mode;
        end
    end

    // Endpoint byte 0 carries input levels; pins not used as inputs read 0.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ep_reg <= 16'h0;
        end else begin
            ep_reg <= 16'h0;
            ep_reg[ata_gate_pkg::EP_MEDIA_BIT] <=
                gpi_mode && media_present_in_i;
            ep_reg[ata_gate_pkg::EP_GRANT_BIT] <=
                gpi_mode && power_grant_n_i;
            ep_reg[ata_gate_pkg::EP_PULLUP_BIT] <=
                gpi_mode && pullup_source_pin_i;
        end
    end

    // Events worth software attention, one cycle each.
    always_comb begin
        ev_vec = '0;
        ev_vec[ata_gate_pkg::EV_MEDIA]     = present_next != present_reg;
        ev_vec[ata_gate_pkg::EV_ACTIVE]    = active_next != active_reg;
        ev_vec[ata_gate_pkg::EV_READY]     = startup_done && !done_q_reg;
        ev_vec[ata_gate_pkg::EV_DRIVE_IRQ] = drive_irq_in_i
                                             && !drive_irq_q_reg;
    end

    assign ev_clr = (rb.wr_en && rb.wr_strb[0]
                     && rb.wr_addr == ata_gate_pkg::IRQ_STAT_OFS)
                    ? rb.wr_data[EV_W_L:0] : '0;

    // Sticky status; a new event beats a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_vec;
        end
    end

    // Interrupt mask, one enable per status bit.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_mask_reg <= '0;
        end else if (rb.wr_en && rb.wr_strb[0]
                     && rb.wr_addr == ata_gate_pkg::IRQ_MASK_OFS) begin
            irq_mask_reg <= rb.wr_data[EV_W_L:0];
        end
    end

    assign irq_o                   = |(irq_stat_reg & irq_mask_reg);
    assign interrupt_in_endpoint_o = ep_reg;
    assign pins_active_o           = active_reg;
    assign media_present_o         = present_reg;

    // Write decode only flags unmapped addresses; stores happen above.
    always_comb begin
        unique case (rb.wr_addr)
            ata_gate_pkg::CFG_OFS,
            ata_gate_pkg::STATUS_OFS,
            ata_gate_pkg::IRQ_STAT_OFS,
            ata_gate_pkg::IRQ_MASK_OFS,
            ata_gate_pkg::EP_DATA_OFS: rb.wr_err = 1'h0;
            default:                   rb.wr_err = 1'h1;
        endcase
    end

    // Read mux; unused bits read as zero.
    always_comb begin
        rb.rd_data = 32'h0;
        rb.rd_err  = 1'h0;
        unique case (rb.rd_addr)
            ata_gate_pkg::CFG_OFS:      rb.rd_data[7:0] = cfg_reg;
            ata_gate_pkg::STATUS_OFS: begin
                rb.rd_data[0] = active_reg;
                rb.rd_data[1] = startup_done;
                rb.rd_data[2] = present_reg;
                rb.rd_data[3] = drive_irq_in_i;
            end
            ata_gate_pkg::IRQ_STAT_OFS: rb.rd_data[EV_W_L:0] = irq_stat_reg;
            ata_gate_pkg::IRQ_MASK_OFS: rb.rd_data[EV_W_L:0] = irq_mask_reg;
            ata_gate_pkg::EP_DATA_OFS:  rb.rd_data[15:0] = ep_reg;
            default:                    rb.rd_err = 1'h1;
        endcase
    end

    // Two quiet cycles of the gate must leave every ATA driver off.
    AST_GATE_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!active_next ##1 !active_next) |=>
        (ata_addr_oe_n_o && ata_select_oe_n_o && ata_data_oe_n_o))
        else $error("ATA pins driven while gated off.");

    // The address floats before the wait ends; afterwards, with the gate open, idle lines drive high.
    AST_STARTUP_DRIVE: assert property (@(posedge clk_i)
        disable iff (!rstn_i) (startup_done && active_reg) |=>
        (!ata_addr_oe_n_o && ata_addr_o == 3'h7 && ata_select0_n_o
         && ata_select1_n_o && !ata_select_oe_n_o))
        else $error("Address or selects not high after startup wait.");

    AST_NO_EARLY_DRIVE: assert property (@(posedge clk_i)
        disable iff (!rstn_i) !startup_done |=> ata_addr_oe_n_o)
        else $error("Address driven before startup wait ended.");

    // Presence follows the pin through the configured polarity.
    AST_POLARITY: assert property (@(posedge clk_i)
        disable iff (!rstn_i) (cfg_reg[0] && !gpi_mode) |=>
        (media_present_o == ($past(media_present_in_i) ^ $past(cfg_reg[1]))))
        else $error("Presence does not follow configured polarity.");

    AST_GPI_LEVEL: assert property (@(posedge clk_i)
        disable iff (!rstn_i) gpi_mode |=>
        (interrupt_in_endpoint_o[0] == $past(media_present_in_i)))
        else $error("Endpoint bit 0 does not show the presence pin.");

    AST_GPI_SIDE: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        gpi_mode |=> (pullup_source_pin_oe_n_o && power_grant_n_oe_n_o))
        else $error("Side pins still driven in input role.");

    AST_HIZ_INACTIVE: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        !active_reg |=> (ata_data_oe_n_o && ata_select_oe_n_o))
        else $error("Data or selects driven while inactive.");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ev_vec[0] && ev_clr[0]) |=> irq_stat_reg[0])
        else $error("Event lost against a clear.");
endmodule // ata_pin_gating
`default_nettype wire

// [bench/ata_drive_model.sv]
// Behavioural drive on the far side of the ATA data pins.
`timescale 1ns/1ps
`default_nettype none
module ata_drive_model (
    input  wire logic        clk_i,
    input  wire logic        dev_oe_n_i,
    input  wire logic [15:0] dev_data_i,
    input  wire logic        irq_req_i,
    output logic [15:0]      bus_o,
    output logic             irq_o
);
    logic [15:0] pat_reg = 16'h5a5a;
    // A released bus shows a moving pattern so a stale value never matches.
    always @(posedge clk_i) begin
        pat_reg <= {pat_reg[14:0], ~pat_reg[15]};
    end
    // The wire carries the device value only while it drives.
    assign bus_o = dev_oe_n_i ? pat_reg : dev_data_i;
    assign irq_o = irq_req_i;
endmodule // ata_drive_model
`default_nettype wire

// [bench/ata_pin_gating_tb.sv]
// Self-checking bench for the ATA pin gating block.
`timescale 1ns/1ps
`default_nettype none
module ata_pin_gating_tb;
    logic        clk_i = 0, rstn_i = 0, awv = 0, wv = 0, brdy = 0;
    logic        arv = 0, rrdy = 0, sense = 1, media = 1, irq_req = 0;
    logic        xdrv = 1, pu_pin = 0, gr_pin = 0, pu_en = 0, granted = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  resp;
    logic [15:0] bus, xd = 16'hc3a5;
    wire logic   awr, wr_r, bv, arr, rv, dirq, a_oe, s_oe, d_oe, pu_oe, gr_oe;
    wire logic   act, mp, irq, s0, s1, pu_o, gr_o;
    wire logic [2:0]  addr;
    wire logic [1:0]  br, rr;
    wire logic [31:0] rd_d;
    wire logic [15:0] dout, xout, ep;
    int failures = 0, cmp_count = 0;
    ata_pin_gating #(.DELAY_CYCLES(20)) u_ata_pin_gating (.clk_i(clk_i),
        .rstn_i(rstn_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
        .host_power_sense_enable_i(sense), .media_present_in_i(media),
        .drive_irq_in_i(dirq), .ata_addr_o(addr), .ata_addr_oe_n_o(a_oe),
        .ata_select0_n_o(s0), .ata_select1_n_o(s1),
        .ata_select_oe_n_o(s_oe), .ata_data_i(bus), .ata_data_o(dout),
        .ata_data_oe_n_o(d_oe), .xfer_data_i(xd), .xfer_drive_i(xdrv),
        .xfer_data_o(xout), .pullup_source_pin_i(pu_pin),
        .pullup_source_pin_o(pu_o), .pullup_source_pin_oe_n_o(pu_oe),
        .pullup_enable_i(pu_en), .power_grant_n_i(gr_pin),
        .power_grant_n_o(gr_o), .power_grant_n_oe_n_o(gr_oe),
        .power_granted_i(granted), .interrupt_in_endpoint_o(ep),
        .pins_active_o(act), .media_present_o(mp), .irq_o(irq));
    ata_drive_model u_ata_drive_model (.clk_i(clk_i), .dev_oe_n_i(d_oe),
        .dev_data_i(dout), .irq_req_i(irq_req), .bus_o(bus), .irq_o(dirq));
    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Each half is released when taken; bready stays up until bvalid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (bv === 1'b1) break;
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr_r === 1'b1) wv <= 1'b0;
        end
        resp = br;
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (rv === 1'b1) break;
            if (arv && arr === 1'b1) arv <= 1'b0;
        end
        rdat = rd_d;
        resp = rr;
        rrdy <= 1'b0;
    endtask
    // Address stays undriven until the startup wait ends; then address and selects drive high.
    task automatic t_startup();
        cyc(10);
        chk(a_oe, 1'b1);
        rd(ata_gate_pkg::CFG_OFS);
        chk(rdat, 32'(ata_gate_pkg::CFG_RESET));
        cyc(20);
        chk({a_oe, s_oe, addr, s0, s1}, 7'h1f);
    endtask
    // With the ignore bit clear, sense low parks every ATA pin.
    task automatic t_gate();
        sense <= 1'b0;
        cyc(4);
        chk({act, a_oe, s_oe, d_oe}, 4'h7);
        chk(xout, 16'h0000);
        wr(ata_gate_pkg::CFG_OFS, 32'h1 << ata_gate_pkg::CFG_IGNORE_SENSE_BIT);
        cyc(4);
        chk({act, a_oe, d_oe}, 3'h4);
        chk(xout, xd);
        wr(ata_gate_pkg::CFG_OFS, 32'h0);
        sense <= 1'b1;
    endtask
    // Every polarity against every pin level.
    task automatic t_media();
        for (int p = 0; p < 2; p++) begin
            for (int v = 0; v < 2; v++) begin
                wr(ata_gate_pkg::CFG_OFS, 32'(1 + 2 * p));
                media <= v[0];
                cyc(3);
                chk(mp, v[0] ^ p[0]);
            end
        end
    endtask
    // Input role turns the three side pins into reported inputs.
    task automatic t_gpi();
        wr(ata_gate_pkg::CFG_OFS, 32'h80);
        media <= 1'b1;
        pu_pin <= 1'b1;
        gr_pin <= 1'b1;
        pu_en <= 1'b1;
        cyc(3);
        chk(ep[2:0], 3'h7);
        chk({pu_oe, gr_oe, pu_o, gr_o}, 4'hf);
        media <= 1'b0;
        rd(ata_gate_pkg::EP_DATA_OFS);
        chk(rdat[2:0], 3'h6);
        pu_en <= 1'b0;
        granted <= 1'b1;
        wr(ata_gate_pkg::CFG_OFS, 32'h0);
        cyc(2);
        chk({pu_oe, gr_oe, pu_o, gr_o, ep[2:0]}, 7'h00);
    endtask
    // Drive interrupt raised, masked, unmasked and cleared; unmapped place.
    task automatic t_irq();
        wr(ata_gate_pkg::IRQ_STAT_OFS, 32'hf);
        wr(ata_gate_pkg::IRQ_MASK_OFS, 32'h8);
        chk(irq, 1'b0);
        irq_req <= 1'b1;
        cyc(3);
        chk(irq, 1'b1);
        wr(ata_gate_pkg::IRQ_MASK_OFS, 32'h0);
        cyc(1);
        chk(irq, 1'b0);
        wr(ata_gate_pkg::IRQ_MASK_OFS, 32'h8);
        wr(ata_gate_pkg::IRQ_STAT_OFS, 32'h8);
        cyc(1);
        chk(irq, 1'b0);
        rd(8'h20);
        chk(resp, ata_gate_pkg::RESP_SLVERR);
        chk(rdat, 32'h0);
        wr(8'h20, 32'h1);
        chk(resp, ata_gate_pkg::RESP_SLVERR);
    endtask
    // Main sequence after a six-cycle reset.
    initial begin
        cyc(6);
        rstn_i <= 1'b1;
        t_startup();
        t_gate();
        t_media();
        t_gpi();
        t_irq();
        report_and_stop();
    end
    // A hang ends the run as a failure.
    initial begin
        cyc(5000);
        failures++;
        report_and_stop();
    end
endmodule // ata_pin_gating_tb
`default_nettype wire
